// >>> hw/interrupt_source_dispatch.v
// Notes on behaviour
// - maskable requests need the enable flag and priority; non-maskable ones bypass both
// - every instruction-raised interrupt is non-maskable
// - undefined-instruction opcode always raises its interrupt
// - overflow-trap opcode raises the overflow interrupt only when the overflow flag is 1
// - break opcode raises break; debugger break opcode raises the debugger break
// - software trap takes number 0..63; 8..23 share peripheral vectors
// - traps 0..31 save the stack-select flag, clear it, restore on return
// - traps 32..63 leave the stack-select flag alone
// - every peripheral interrupt saves and clears the stack-select flag
// - reset, pin NMI, watchdog, address match, single step are non-maskable
// - low reset pin resets; low NMI pin raises the NMI
// - enabled address match fires before the instruction starting at that address
// - debug step flag set gives a step interrupt after each instruction
// - peripheral interrupts are maskable and use vectors 8..23
// - serial shared source: collision, or start/stop in I2C mode, or fault with select pin
// - a low on any key pin raises the key interrupt
// - each external pin senses rising, falling, both edges, high or low level
// - fast entry takes 5 cycles, fast return 3 cycles
// - fast entry saves flags and PC to shadows, jumps to fast vector; fast return restores
// - with fast enable set, the level 7 request takes the fast path
// - only a request above the exit threshold may end wait mode
`include "int_dispatch_regs.vh"

module interrupt_source_dispatch #(
   parameter NKEY = 4,
   parameter NPER = 8,
   parameter [5:0] VEC_BASE = `PERIPH_VEC_BASE
) (
   // clock and reset
   input wire clock_i,
   input wire sys_rst_i,
   // register port
   input wire [3:0] addr_i,
   input wire [31:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   output reg [31:0] rdata_o,
   // instruction decoder and flag register
   input wire op_valid_i,
   input wire [2:0] op_i,
   input wire [5:0] trap_num_i,
   input wire insn_start_i,
   input wire [23:0] fetch_pc_i,
   input wire [15:0] flag_i,
   input wire [23:0] pc_i,
   // pins
   input wire reset_pin_n_i,
   input wire nmi_pin_n_i,
   input wire [5:0] ext_int_pin_i,
   input wire [NKEY-1:0] key_input_pin_n_i,
   // on-chip sources
   input wire watchdog_i,
   input wire [NPER-1:0] periph_req_i,
   input wire ser_collision_i,
   input wire ser_startstop_i,
   input wire ser_fault_i,
   input wire ser_i2c_mode_i,
   input wire ser_ss_sel_i,
   // to the CPU core
   output reg take_o,
   output reg [3:0] take_class_o,
   output reg [5:0] take_vec_o,
   output reg isp_select_o,
   output reg u_restore_o,
   output reg u_restore_val_o,
   output reg fast_go_o,
   output reg [23:0] fast_pc_o,
   output reg fast_ret_o,
   output reg [15:0] ret_flag_o,
   output reg [23:0] ret_pc_o,
   output reg wake_o,
   output reg dev_reset_o
);

   localparam NSRC = 8 + NPER;
   localparam NPIN = 8 + NKEY;
   localparam [2:0] ST_IDLE = 3'b001;
   localparam [2:0] ST_FENT = 3'b010;
   localparam [2:0] ST_FRET = 3'b100;

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   // bit 0 reset, bit 1 nmi, bits 7:2 ext pins, above that keys
   wire [NPIN-1:0] pins = {key_input_pin_n_i, ext_int_pin_i, nmi_pin_n_i, reset_pin_n_i};
   reg [NPIN-1:0] s1_r, s2_r, s3_r, filt_r, prev_r;
   // a change counts only once stages two and three agree
   wire [NPIN-1:0] filt_nxt = (s2_r & s3_r) | (filt_r & (s2_r ^ s3_r));

   always @(posedge clock_i)
   begin
      if (sys_rst_i)
      begin
         s1_r <= {NPIN{1'b1}};
         s2_r <= {NPIN{1'b1}};
         s3_r <= {NPIN{1'b1}};
         filt_r <= {NPIN{1'b1}};
         prev_r <= {NPIN{1'b1}};
      end
      else
      begin
         s1_r <= pins;
         s2_r <= s1_r;
         s3_r <= s2_r;
         filt_r <= filt_nxt;
         prev_r <= filt_r;
      end
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   reg [4:0] ctrl_r;
   reg [23:0] fvec_r;
   reg [23:0] amatch_r;
   reg [3*NSRC-1:0] prio_r;
   reg [17:0] pmode_r;
   reg [15:0] svf_r;
   reg [23:0] svp_r;
   reg u_saved_r;
   reg [2:0] state_r;
   reg [2:0] cnt_r;
   reg [6:0] edge_pend_r;
   reg nmi_pend_r, wdt_pend_r, am_pend_r, step_pend_r;

   function edge_hit;
      input [2:0] mode;
      input cur;
      input prv;
      begin
         if (mode == `PM_RISE)
            edge_hit = cur & ~prv;
         else if (mode == `PM_FALL)
            edge_hit = ~cur & prv;
         else if (mode == `PM_BOTH)
            edge_hit = cur ^ prv;
         else
            edge_hit = 1'b0;
      end
   endfunction

   // ----------------------------------------
   // request sources
   // ----------------------------------------
   wire key_low = ~&filt_r[NPIN-1:8];
   wire key_low_prev = ~&prev_r[NPIN-1:8];
   // select pin function outranks I2C mode when both are set
   wire ser_req = ser_ss_sel_i ? ser_fault_i :
                  (ser_i2c_mode_i ? ser_startstop_i : ser_collision_i);

   reg [6:0] edge_set;
   reg [NSRC-1:0] src_req;
   integer k;

   always @*
   begin
      edge_set = 7'h00;
      src_req = {NSRC{1'b0}};
      for (k = 0; k < 6; k = k + 1)
      begin
         edge_set[k] = edge_hit(pmode_r[3*k +: 3], filt_r[k+2], prev_r[k+2]);
         if (pmode_r[3*k +: 3] == `PM_HIGH)
            src_req[k] = filt_r[k+2];
         else if (pmode_r[3*k +: 3] == `PM_LOW)
            src_req[k] = ~filt_r[k+2];
         else
            src_req[k] = edge_pend_r[k];
      end
      edge_set[6] = key_low & ~key_low_prev;
      src_req[6] = edge_pend_r[6];
      src_req[7] = ser_req;
      src_req[NSRC-1:8] = periph_req_i;
   end

   // ----------------------------------------
   // maskable arbitration
   // ----------------------------------------
   reg [2:0] best_lvl;
   reg [4:0] best_idx;
   reg wake_any;
   integer i;

   always @*
   begin
      best_lvl = 3'h0;
      best_idx = 5'h00;
      wake_any = 1'b0;
      // lowest index wins a tie between equal levels
      for (i = 0; i < NSRC; i = i + 1)
      begin
         if (src_req[i] && prio_r[3*i +: 3] > best_lvl)
         begin
            best_lvl = prio_r[3*i +: 3];
            best_idx = i[4:0];
         end
         if (src_req[i] && prio_r[3*i +: 3] > ctrl_r[2:0])
            wake_any = 1'b1;
      end
   end

   wire [2:0] processor_irq_level = flag_i[`FLG_IPL_LSB +: 3];
   wire mask_ok = flag_i[`FLG_I_BIT] && best_lvl != 3'h0 && best_lvl > processor_irq_level;
   wire fast_sel = ctrl_r[`CTRL_FAST_BIT] && best_lvl == `FAST_LEVEL;

   // ----------------------------------------
   // event selection
   // ----------------------------------------
   wire ovf_taken = op_i == `OP_INTO && flag_i[`FLG_O_BIT];
   wire am_set = ctrl_r[`CTRL_AM_BIT] && insn_start_i && fetch_pc_i == amatch_r;
   wire step_set = op_valid_i && flag_i[`FLG_D_BIT];
   wire idle = state_r == ST_IDLE;

   reg [3:0] sel_cls;
   reg [5:0] sel_vec;
   reg sel_u, sel_fast, clr_nmi, clr_wdt, clr_am, clr_step, clr_mask;

   always @*
   begin
      sel_cls = `CLS_NONE;
      sel_vec = 6'h00;
      sel_u = 1'b0;
      sel_fast = 1'b0;
      clr_nmi = 1'b0;
      clr_wdt = 1'b0;
      clr_am = 1'b0;
      clr_step = 1'b0;
      clr_mask = 1'b0;
      // instruction traps come first: they have no latch and would be lost
      if (idle && op_valid_i && op_i == `OP_UND)
         sel_cls = `CLS_UND;
      else if (idle && op_valid_i && ovf_taken)
         sel_cls = `CLS_OVF;
      else if (idle && op_valid_i && op_i == `OP_BRK)
         sel_cls = `CLS_BRK;
      else if (idle && op_valid_i && op_i == `OP_DEBUG_BREAK_OP)
         sel_cls = `CLS_DBRK;
      else if (idle && op_valid_i && op_i == `OP_INT)
      begin
         sel_cls = `CLS_SWI;
         sel_vec = trap_num_i;
         sel_u = trap_num_i < `SWI_USTACK_LIMIT;
      end
      else if (idle && nmi_pend_r)
      begin
         sel_cls = `CLS_NMI;
         clr_nmi = 1'b1;
      end
      else if (idle && wdt_pend_r)
      begin
         sel_cls = `CLS_WDT;
         clr_wdt = 1'b1;
      end
      else if (idle && am_pend_r)
      begin
         sel_cls = `CLS_AMATCH;
         clr_am = 1'b1;
      end
      else if (idle && step_pend_r)
      begin
         sel_cls = `CLS_STEP;
         clr_step = 1'b1;
      end
      // a level source drops only once it has seen take_o, so skip that cycle
      else if (idle && mask_ok && !take_o)
      begin
         sel_cls = fast_sel ? `CLS_FAST : `CLS_PERIPH;
         sel_vec = VEC_BASE + {1'b0, best_idx};
         sel_u = 1'b1;
         sel_fast = fast_sel;
         clr_mask = 1'b1;
      end
   end

   wire [6:0] edge_clr = (clr_mask && best_idx < 5'd7) ? (7'h01 << best_idx[2:0]) : 7'h00;

   // ----------------------------------------
   // pending latches, set wins over clear
   // ----------------------------------------
   always @(posedge clock_i)
   begin
      if (sys_rst_i)
      begin
         edge_pend_r <= 7'h00;
         nmi_pend_r <= 1'b0;
         wdt_pend_r <= 1'b0;
         am_pend_r <= 1'b0;
         step_pend_r <= 1'b0;
      end
      else
      begin
         edge_pend_r <= (edge_pend_r & ~edge_clr) | edge_set;
         nmi_pend_r <= (nmi_pend_r & ~clr_nmi) | (~filt_r[1] & prev_r[1]);
         wdt_pend_r <= (wdt_pend_r & ~clr_wdt) | watchdog_i;
         am_pend_r <= (am_pend_r & ~clr_am) | am_set;
         step_pend_r <= (step_pend_r & ~clr_step) | step_set;
      end
   end

   // ----------------------------------------
   // accept, fast entry and fast return
   // ----------------------------------------
   always @(posedge clock_i)
   begin
      if (sys_rst_i)
      begin
         state_r <= ST_IDLE;
         cnt_r <= 3'h0;
         take_o <= 1'b0;
         take_class_o <= `CLS_NONE;
         take_vec_o <= 6'h00;
         isp_select_o <= 1'b0;
         u_restore_o <= 1'b0;
         u_restore_val_o <= 1'b0;
         u_saved_r <= 1'b0;
         fast_go_o <= 1'b0;
         fast_pc_o <= 24'h00_0000;
         fast_ret_o <= 1'b0;
         ret_flag_o <= 16'h0000;
         ret_pc_o <= 24'h00_0000;
         svf_r <= 16'h0000;
         svp_r <= 24'h00_0000;
         wake_o <= 1'b0;
         dev_reset_o <= 1'b1;
      end
      else
      begin
         take_o <= sel_cls != `CLS_NONE;
         take_class_o <= sel_cls;
         take_vec_o <= sel_vec;
         isp_select_o <= sel_u;
         u_restore_o <= 1'b0;
         fast_go_o <= 1'b0;
         fast_ret_o <= 1'b0;
         wake_o <= wake_any;
         dev_reset_o <= ~filt_r[0];
         // one saved copy: nesting relies on the core stacking its flags
         if (sel_u)
            u_saved_r <= flag_i[`FLG_U_BIT];
         case (state_r)
            ST_IDLE:
            begin
               if (sel_fast)
               begin
                  svf_r <= flag_i;
                  svp_r <= pc_i;
                  cnt_r <= 3'h2;
                  state_r <= ST_FENT;
               end
               else if (op_valid_i && op_i == `OP_FAST_RETURN_OP)
               begin
                  cnt_r <= 3'h2;
                  state_r <= ST_FRET;
               end
               else if (op_valid_i && op_i == `OP_REIT)
               begin
                  u_restore_o <= 1'b1;
                  u_restore_val_o <= u_saved_r;
               end
            end
            ST_FENT:
            begin
               if (cnt_r + 3'h1 == `FAST_ENTRY_CYC)
               begin
                  fast_go_o <= 1'b1;
                  fast_pc_o <= fvec_r;
                  state_r <= ST_IDLE;
               end
               else
                  cnt_r <= cnt_r + 3'h1;
            end
            ST_FRET:
            begin
               if (cnt_r + 3'h1 == `FAST_RET_CYC)
               begin
                  fast_ret_o <= 1'b1;
                  ret_flag_o <= svf_r;
                  ret_pc_o <= svp_r;
                  state_r <= ST_IDLE;
               end
               else
                  cnt_r <= cnt_r + 3'h1;
            end
            default:
               state_r <= ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // register port
   // ----------------------------------------
   integer j;

   always @(posedge clock_i)
   begin
      if (sys_rst_i)
      begin
         ctrl_r <= `CTRL_RST;
         fvec_r <= `FVEC_RST;
         amatch_r <= `AMATCH_RST;
         pmode_r <= `PINMODE_RST;
         prio_r <= {3*NSRC{1'b0}};
      end
      else if (wr_i)
      begin
         if (addr_i == `REG_CTRL)
            ctrl_r <= wdata_i[4:0];
         else if (addr_i == `REG_FVEC)
            fvec_r <= wdata_i[23:0];
         else if (addr_i == `REG_AMATCH)
            amatch_r <= wdata_i[23:0];
         else if (addr_i == `REG_PINMODE)
            pmode_r <= wdata_i[17:0];
         for (j = 0; j < NSRC; j = j + 1)
            if (addr_i == `REG_PRIO0 + {1'b0, j[5:3]})
               prio_r[3*j +: 3] <= wdata_i[4*j[2:0] +: 3];
      end
   end

   reg [31:0] rd_val;
   integer m;

   always @*
   begin
      rd_val = 32'h0000_0000;
      if (addr_i == `REG_CTRL)
         rd_val[4:0] = ctrl_r;
      else if (addr_i == `REG_FVEC)
         rd_val[23:0] = fvec_r;
      else if (addr_i == `REG_AMATCH)
         rd_val[23:0] = amatch_r;
      else if (addr_i == `REG_PRIO0 || addr_i == `REG_PRIO1)
      begin
         for (m = 0; m < NSRC; m = m + 1)
            if (addr_i == `REG_PRIO0 + {1'b0, m[5:3]})
               rd_val[4*m[2:0] +: 3] = prio_r[3*m +: 3];
      end
      else if (addr_i == `REG_PINMODE)
         rd_val[17:0] = pmode_r;
      else if (addr_i == `REG_PEND)
         rd_val[NSRC+3:0] = {step_pend_r, am_pend_r, wdt_pend_r, nmi_pend_r, src_req};
      else if (addr_i == `REG_STATE)
         rd_val[3:0] = {u_saved_r, state_r};
      else if (addr_i == `REG_SVF)
         rd_val[15:0] = svf_r;
      else if (addr_i == `REG_SVP)
         rd_val[23:0] = svp_r;
   end

   always @(posedge clock_i)
   begin
      if (sys_rst_i)
         rdata_o <= 32'h0000_0000;
      else if (rd_i)
         rdata_o <= rd_val;
      else
         rdata_o <= 32'h0000_0000;
   end

endmodule

// >>> hw/int_dispatch_regs.vh
`ifndef INT_DISPATCH_REGS_VH
`define INT_DISPATCH_REGS_VH

// ----------------------------------------
// register word addresses
// ----------------------------------------
`define REG_CTRL 4'h0
`define REG_FVEC 4'h1
`define REG_AMATCH 4'h2
`define REG_PRIO0 4'h3
`define REG_PRIO1 4'h4
`define REG_PINMODE 4'h5
`define REG_PEND 4'h6
`define REG_STATE 4'h7
`define REG_SVF 4'h8
`define REG_SVP 4'h9

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define CTRL_FAST_BIT 3
`define CTRL_AM_BIT 4
`define CTRL_RST 5'h00
`define FVEC_RST 24'h00_0000
`define AMATCH_RST 24'h00_0000
`define PINMODE_RST 18'h0_0000
`define FLG_O_BIT 2
`define FLG_D_BIT 5
`define FLG_I_BIT 6
`define FLG_U_BIT 7
`define FLG_IPL_LSB 12
`define FAST_LEVEL 3'h7
`define PERIPH_VEC_BASE 6'h08
`define SWI_USTACK_LIMIT 6'h20

// ----------------------------------------
// pin sense modes
// ----------------------------------------
`define PM_RISE 3'h0
`define PM_FALL 3'h1
`define PM_BOTH 3'h2
`define PM_HIGH 3'h3
`define PM_LOW 3'h4

// ----------------------------------------
// decoder op classes
// ----------------------------------------
`define OP_NONE 3'h0
`define OP_UND 3'h1
`define OP_INTO 3'h2
`define OP_BRK 3'h3
`define OP_DEBUG_BREAK_OP 3'h4
`define OP_INT 3'h5
`define OP_REIT 3'h6
`define OP_FAST_RETURN_OP 3'h7

// ----------------------------------------
// accepted interrupt classes
// ----------------------------------------
`define CLS_NONE 4'h0
`define CLS_UND 4'h1
`define CLS_OVF 4'h2
`define CLS_BRK 4'h3
`define CLS_DBRK 4'h4
`define CLS_SWI 4'h5
`define CLS_NMI 4'h6
`define CLS_WDT 4'h7
`define CLS_AMATCH 4'h8
`define CLS_STEP 4'h9
`define CLS_PERIPH 4'hA
`define CLS_FAST 4'hB

// ----------------------------------------
// fast path timing in cycles
// ----------------------------------------
`define FAST_ENTRY_CYC 3'h5
`define FAST_RET_CYC 3'h3

`endif

// >>> tb/periph_model.sv
module periph_model #(
   parameter NPER = 8
) (
   // clock and reset
   input wire clock_i,
   input wire sys_rst_i,
   // request raising from the bench
   input wire raise_i,
   input wire [2:0] idx_i,
   // accept signals from the block
   input wire take_i,
   input wire [3:0] take_class_i,
   input wire [5:0] take_vec_i,
   // level requests
   output logic [NPER-1:0] periph_req_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // ----------------------------------------
   // level sources, held until serviced
   // ----------------------------------------
   // a fast accept clears every request, not only the source in take_vec_i, so only one source may sit at level 7
   always @(posedge clock_i)
   begin
      if (sys_rst_i)
         periph_req_o <= '0;
      else if (take_i && take_class_i == 4'hA)
         periph_req_o[take_vec_i - 6'h10] <= 1'b0;
      else if (take_i && take_class_i == 4'hB)
         periph_req_o <= '0;
      else if (raise_i)
         periph_req_o[idx_i] <= 1'b1;
   end
endmodule

// >>> tb/dispatch_sva.sv
`include "int_dispatch_regs.vh"
module dispatch_sva (
   // clock and reset
   input wire clock_i,
   input wire sys_rst_i,
   // inputs
   input wire [3:0] addr_i,
   input wire [31:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   input wire op_valid_i,
   input wire [2:0] op_i,
   input wire [5:0] trap_num_i,
   input wire [15:0] flag_i,
   input wire [23:0] pc_i,
   // outputs
   input wire [31:0] rdata_o,
   input wire take_o,
   input wire [3:0] take_class_o,
   input wire [5:0] take_vec_o,
   input wire isp_select_o,
   input wire fast_go_o,
   input wire [23:0] fast_pc_o,
   input wire fast_ret_o,
   input wire [23:0] ret_pc_o,
   input wire dev_reset_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (sys_rst_i);
   logic [23:0] fvec_r;
   logic [23:0] spc_r;
   wire ien = flag_i[`FLG_I_BIT];
   // ----------------------------------------
   // shadow copies of what the block should hold
   // ----------------------------------------
   always @(posedge clock_i)
   begin
      if (sys_rst_i)
         fvec_r <= 24'h00_0000;
      else if (wr_i && addr_i == `REG_FVEC)
         fvec_r <= wdata_i[23:0];
   end
   always @(posedge clock_i)
   begin
      if (take_o && take_class_o == `CLS_FAST)
         spc_r <= $past(pc_i);
   end
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   dev_rst_a: assert property (disable iff (1'b0) sys_rst_i |=> dev_reset_o)
      else $error("device reset not held during system reset");
   rdata_idle_a: assert property (!rd_i |=> rdata_o == 32'h0000_0000)
      else $error("read data not zero outside a read");
   und_take_a: assert property (op_valid_i && op_i == `OP_UND |=>
      take_o && take_class_o == `CLS_UND) else $error("undefined opcode not taken");
   dbrk_take_a: assert property (op_valid_i && op_i == `OP_DEBUG_BREAK_OP |=>
      take_o && take_class_o == `CLS_DBRK) else $error("debug break not taken");
   ovf_set_a: assert property (op_valid_i && op_i == `OP_INTO && flag_i[`FLG_O_BIT] |=>
      take_o && take_class_o == `CLS_OVF) else $error("overflow trap not taken");
   ovf_clear_a: assert property (op_valid_i && op_i == `OP_INTO && !flag_i[`FLG_O_BIT] |=>
      !(take_o && take_class_o == `CLS_OVF)) else $error("overflow trap taken with flag clear");
   swi_take_a: assert property (op_valid_i && op_i == `OP_INT |=> take_o &&
      take_vec_o == $past(trap_num_i) && isp_select_o == ($past(trap_num_i) < 6'h20))
      else $error("software trap vector or stack select wrong");
   periph_mask_a: assert property (take_o && take_class_o == `CLS_PERIPH |->
      $past(ien) && isp_select_o) else $error("maskable accept without enable or stack select");
   fast_entry_a: assert property (take_o && take_class_o == `CLS_FAST |=> !fast_go_o ##1
      !fast_go_o ##1 fast_go_o && fast_pc_o == fvec_r) else $error("fast entry timing or target");
   fast_ret_a: assert property (op_valid_i && op_i == `OP_FAST_RETURN_OP |=> !fast_ret_o ##1
      fast_ret_o && ret_pc_o == spc_r) else $error("fast return timing or pc");
   swi_c: cover property (take_o && take_class_o == `CLS_SWI && !isp_select_o);
   periph_c: cover property (take_o && take_class_o == `CLS_PERIPH);
   fast_c: cover property (fast_go_o ##[1:20] fast_ret_o);
endmodule

bind interrupt_source_dispatch dispatch_sva chk (.*);

// >>> tb/testbench.sv
`include "int_dispatch_regs.vh"
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {logic [3:0] c; logic [5:0] v; logic i; logic cv; logic ci;} tk_t;
   logic clock_i = 0, sys_rst_i = 1, wr_i = 0, rd_i = 0, op_valid_i = 0, insn_start_i = 0;
   logic reset_pin_n_i = 1, nmi_pin_n_i = 1, watchdog_i = 0, raise = 0, rd_d = 0;
   logic ser_collision_i = 0, ser_startstop_i = 0, ser_fault_i = 0;
   logic ser_i2c_mode_i = 0, ser_ss_sel_i = 0;
   logic [3:0] addr_i = 0, key_input_pin_n_i = 4'hF;
   logic [31:0] wdata_i = 0;
   logic [2:0] op_i = 0, ridx = 0;
   logic [5:0] trap_num_i = 0, ext_int_pin_i = 0;
   logic [23:0] fetch_pc_i = 0, pc_i = 0, fv, am;
   logic [15:0] flag_i = 0;
   logic [7:0] periph_req_i;
   logic [31:0] rdata_o;
   logic take_o, isp_select_o, u_restore_o, u_restore_val_o, fast_go_o, fast_ret_o;
   logic wake_o, dev_reset_o;
   logic [3:0] take_class_o;
   logic [5:0] take_vec_o;
   logic [23:0] fast_pc_o, ret_pc_o;
   logic [15:0] ret_flag_o;
   tk_t tq[$];
   tk_t t;
   logic [31:0] rq[$];
   logic [23:0] fq[$];
   logic [39:0] bq[$];
   logic uq[$];
   int n_fail = 0, n_tests = 0, seed, k;
   logic [5:0] traps[6] = '{6'h00, 6'h1F, 6'h20, 6'h2B, 6'h3F, 6'h0A};
   logic [2:0] ops[4] = '{`OP_UND, `OP_INTO, `OP_BRK, `OP_DEBUG_BREAK_OP};
   logic [3:0] cls[4] = '{`CLS_UND, `CLS_OVF, `CLS_BRK, `CLS_DBRK};

   interrupt_source_dispatch DUT (.*);
   periph_model PM (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .raise_i(raise), .idx_i(ridx),
      .take_i(take_o), .take_class_i(take_class_o), .take_vec_i(take_vec_o),
      .periph_req_o(periph_req_i));

   always #50 clock_i = ~clock_i;
   // ----------------------------------------
   // bus, op and expectation tasks
   // ----------------------------------------
   task chk(input string n, input logic [39:0] e, input logic [39:0] g);
      n_tests++;
      if (g !== e)
      begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clock_i);
      addr_i <= a; wdata_i <= d; wr_i <= 1;
      @(posedge clock_i);
      wr_i <= 0;
   endtask
   task rd(input logic [3:0] a, input logic [31:0] e);
      rq.push_back(e);
      @(posedge clock_i);
      addr_i <= a; rd_i <= 1;
      @(posedge clock_i);
      rd_i <= 0;
   endtask
   task op(input logic [2:0] o, input logic [5:0] n);
      @(posedge clock_i);
      op_valid_i <= 1; op_i <= o; trap_num_i <= n;
      @(posedge clock_i);
      op_valid_i <= 0;
      repeat (3) @(posedge clock_i);
   endtask
   task ex(input logic [3:0] c, input logic [5:0] v, input logic i, input logic cv, ci);
      tq.push_back('{c, v, i, cv, ci});
   endtask
   task results;
      chk("leftover expectations", 0, tq.size() + rq.size() + fq.size() + bq.size() + uq.size());
      $display("tests %0d failures %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // ----------------------------------------
   // result monitor
   // ----------------------------------------
   always @(posedge clock_i) rd_d <= rd_i;
   always @(negedge clock_i)
   begin
      if (rd_d)
         chk("read data", rq.pop_front(), rdata_o);
      if (fast_go_o === 1'b1)
         chk("fast target", fq.pop_front(), fast_pc_o);
      if (fast_ret_o === 1'b1)
         chk("fast restore", bq.pop_front(), {ret_flag_o, ret_pc_o});
      if (u_restore_o === 1'b1)
         chk("restore value", uq.pop_front(), u_restore_val_o);
      if (take_o === 1'b1 && tq.size() == 0)
         chk("unexpected take", 0, take_class_o);
      else if (take_o === 1'b1)
      begin
         t = tq.pop_front();
         chk("take class", t.c, take_class_o);
         if (t.cv)
            chk("take vector", t.v, take_vec_o);
         if (t.ci)
            chk("stack select", t.i, isp_select_o);
      end
   end
   initial
   begin
      #500_000;
      n_fail++;
      results;
   end
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial
   begin
      seed = $urandom(32'h0000_88e9);
      repeat (6) @(posedge clock_i);
      sys_rst_i <= 0;
      repeat (6) @(posedge clock_i);
      fv = 24'($urandom);
      am = 24'($urandom);
      rd(`REG_CTRL, 0);
      rd(4'hF, 0);
      wr(`REG_FVEC, {8'h00, fv});
      wr(4'hF, 32'hFFFF_FFFF);
      rd(`REG_FVEC, {8'h00, fv});
      op(`OP_INTO, 0);
      flag_i <= 16'h0084;
      for (k = 0; k < 4; k++)
      begin
         ex(cls[k], 0, 0, 0, 0);
         op(ops[k], 0);
      end
      traps[5] = 6'($urandom);
      for (k = 0; k < 6; k++)
      begin
         ex(`CLS_SWI, traps[k], traps[k] < 6'h20, 1, 1);
         op(`OP_INT, traps[k]);
      end
      // stack-select flag now clear: the return must bring back the saved 1
      flag_i <= 16'h0004;
      uq.push_back(1'b1);
      op(`OP_REIT, 0);
      ex(`CLS_NMI, 0, 0, 0, 0);
      nmi_pin_n_i <= 0;
      repeat (5) @(posedge clock_i);
      nmi_pin_n_i <= 1;
      repeat (4) @(posedge clock_i);
      ex(`CLS_WDT, 0, 0, 0, 0);
      watchdog_i <= 1;
      @(posedge clock_i);
      watchdog_i <= 0;
      flag_i <= 16'h0020;
      ex(`CLS_STEP, 0, 0, 0, 0);
      op(`OP_NONE, 0);
      flag_i <= 16'h0040;
      wr(`REG_AMATCH, {8'h00, am});
      wr(`REG_CTRL, 32'h0000_0010);
      for (k = 1; k >= 0; k--)
      begin
         if (k == 0)
            ex(`CLS_AMATCH, 0, 0, 0, 0);
         @(posedge clock_i);
         insn_start_i <= 1; fetch_pc_i <= am + 24'(k);
         @(posedge clock_i);
         insn_start_i <= 0;
         repeat (4) @(posedge clock_i);
      end
      wr(`REG_CTRL, 0);
      // level 0 sources never win, so pin noise must stay silent
      for (k = 0; k < 16; k++)
      begin
         @(posedge clock_i);
         {ext_int_pin_i, key_input_pin_n_i, ser_collision_i, ser_fault_i} <= 12'($urandom);
         {ser_startstop_i, ser_i2c_mode_i, ser_ss_sel_i} <= 3'($urandom);
      end
      flag_i <= 16'h3000;
      wr(`REG_PRIO1, 32'h0000_0003);
      @(posedge clock_i);
      raise <= 1; ridx <= 0;
      @(posedge clock_i);
      raise <= 0;
      repeat (5) @(negedge clock_i);
      chk("wake", 1, wake_o);
      @(posedge clock_i);
      flag_i <= 16'h3040;
      repeat (5) @(posedge clock_i);
      ex(`CLS_PERIPH, 6'h10, 1, 1, 1);
      wr(`REG_PRIO1, 32'h0000_0004);
      repeat (6) @(posedge clock_i);
      pc_i <= 24'($urandom);
      flag_i <= 16'h0040;
      wr(`REG_CTRL, 32'h0000_0008);
      wr(`REG_PRIO1, 32'h0000_0007);
      ex(`CLS_FAST, 0, 0, 0, 0);
      fq.push_back(fv);
      bq.push_back({16'h0040, pc_i});
      @(posedge clock_i);
      raise <= 1; ridx <= 0;
      @(posedge clock_i);
      raise <= 0;
      repeat (8) @(posedge clock_i);
      op(`OP_FAST_RETURN_OP, 0);
      wr(`REG_CTRL, 0);
      repeat (6) @(posedge clock_i);
      reset_pin_n_i <= 0;
      repeat (6) @(negedge clock_i);
      chk("device reset", 1, dev_reset_o);
      @(posedge clock_i);
      reset_pin_n_i <= 1;
      repeat (6) @(negedge clock_i);
      chk("device reset", 0, dev_reset_o);
      results;
   end
endmodule
